// ==== hdl/hvsw_pkg.sv ====
// constants and types shared by the hv status and wake-pin block
`default_nettype none
package hvsw_pkg;
  // ==================================================================
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned XFER_NS = 10_000;
  localparam int unsigned XFER_CYC = (XFER_NS + CLK_PERIOD_NS - 1) /
                                     CLK_PERIOD_NS;
  localparam longint unsigned MONO_MS = 1300;
  localparam int unsigned MONO_CYC = int'((MONO_MS * 64'd1_000_000) /
                                          CLK_PERIOD_NS);
  localparam int unsigned WSHORT_US = 400;
  localparam int unsigned WSHORT_CYC = (WSHORT_US * 1000 +
                                        CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==================================================================
  // command port layout and register indices
  localparam int CMD_SEL_LSB = 0;
  localparam int CMD_WR_BIT = 3;
  localparam logic [1:0] REG_CFG_FIRST = 2'h0;
  localparam logic [1:0] REG_CFG_SECOND = 2'h1;
  localparam logic [1:0] REG_LIVE_MON = 2'h2;
  localparam logic [1:0] REG_CHG_STA = 2'h3;
  // ==================================================================
  // configuration fields
  localparam int CF1_LVF_EN = 2;
  localparam int CF1_PSM_EN = 3;
  localparam int CF1_WAKE_REQ = 4;
  localparam int CF2_MONO_DIS = 1;
  localparam int CF2_REENABLE = 3;
  localparam int CF2_WAKE_IN = 4;
  localparam logic [7:0] CFG_FIRST_RST = 8'h00;
  localparam logic [7:0] CFG_SECOND_RST = 8'h00;
  localparam logic [7:0] CHG_STA_RST = 8'h00;
  // ==================================================================
  // monitor and status bit positions
  localparam int MON_WAKE_RB = 7;
  localparam int MON_THERM = 6;
  localparam int MON_AUX_RB = 5;
  localparam int MON_BUF = 4;
  localparam int MON_LVF = 3;
  localparam int ST_PSM = 5;
  localparam int ST_WAKE_EDGE = 4;
  localparam int ST_THERM = 3;
  localparam int ST_BUS_SC = 2;
  localparam int ST_AUX_SC = 1;
  localparam int ST_WAKE_SC = 0;
  // synchronised input vector positions
  localparam int SI_WAKE = 0;
  localparam int SI_AUX = 1;
  localparam int SI_THERM = 2;
  localparam int SI_BUS_SC = 3;
  localparam int SI_AUX_SC = 4;
  localparam int SI_WAKE_OC = 5;
  localparam int SI_SUP_LOW = 6;
  localparam int SI_CORE_LOW = 7;
  localparam int SI_BUF = 8;
  localparam int SI_W = 9;
  typedef enum logic [1:0] {XF_IDLE, XF_HOST, XF_AUTO} hvsw_xfer_t;
endpackage : hvsw_pkg
`default_nettype wire

// ==== hdl/hvsw_tmr_if.sv ====
// run/done carrier between the block and its interval timers
`default_nettype none
interface hvsw_tmr_if;
  logic run;
  logic done;
  modport ctl (output run, input done);
  modport tmr (input run, output done);
endinterface : hvsw_tmr_if
`default_nettype wire

// ==== hdl/hvsw_timer.sv ====
// interval timer: done while run has lasted LIMIT cycles
`default_nettype none
module hvsw_timer #(
  parameter int unsigned LIMIT = 16
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // run and done
  hvsw_tmr_if.tmr t
);
  logic [31:0] cnt_q;
  assign t.done = t.run && (cnt_q == 32'(LIMIT - 1));
  always_ff @(posedge mclk_in) begin
    if (srst_in || !t.run) begin
      cnt_q <= 32'h0000_0000;
    end else if (!t.done) begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end
endmodule : hvsw_timer
`default_nettype wire

// ==== hdl/hvsw_sync.sv ====
// two-flop synchroniser for pin and analog levels
`default_nettype none
module hvsw_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // levels
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_q;
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      meta_q <= '0;
      q_out <= '0;
    end else begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end
endmodule : hvsw_sync
`default_nettype wire

// ==== hdl/hvsw_top.sv ====
// hv status, change-status and wake-pin logic behind command/data port
// What this block does
// R1: input mode shows wake pin on monitor bit7
// R2: overtemperature status bit; shutdown kills all drivers
// R3: monitor bit6 set after thermal shutdown
// R4: readback mode shows aux pin on bit5
// R5: monitor bit4 mirrors converter buffer enable
// R6: low-voltage flag, gated, drops below 2.1V
// R7: bus short monitor flag, cleared by re-enable
// R8: aux short monitor flag, cleared by re-enable
// R9: monitor bit0 flags wake driver short
// R10: change-status captures monitor changes, resets zero
// R11: interrupt auto-copies change-status into data port
// R12: change-status bits 7..6 read zero
// R13: supply monitor bit live, enable gated
// R14: wake edges in input mode interrupt
// R15: bus short sets status, disables driver
// R16: aux short status bit cleared on read
// R17: wake short sets change-status bit0
// R18: wake request is first config bit4
// R19: wake output follows write after transfer
// R20: monoflop drops wake after 1.3 s
// R21: persistent wake overcurrent flags and interrupts
// R22: thermal off wake until re-enable
// R23: intervals counted on core clock
// R24: busy bit high for 10 us transfer
`default_nettype none
module hvsw_top #(
  parameter int unsigned MONO_CYCLES = hvsw_pkg::MONO_CYC,
  parameter int unsigned WSHORT_CYCLES = hvsw_pkg::WSHORT_CYC
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // command and data ports
  input wire logic cmd_wr_in,
  input wire logic [7:0] cmd_wdata_in,
  input wire logic dat_wr_in,
  input wire logic [7:0] dat_wdata_in,
  output logic cmd_busy_out,
  output logic [7:0] dat_rdata_out,
  output logic hv_irq_out,
  // analog status levels
  input wire logic thermal_in,
  input wire logic bus_short_in,
  input wire logic aux_short_in,
  input wire logic wake_oc_in,
  input wire logic supply_low_in,
  input wire logic core_low_in,
  input wire logic adc_buf_en_in,
  // pins
  input wire logic wake_pin_in,
  output logic wake_pin_out,
  output logic wake_pin_oe_out,
  input wire logic aux_pin_in,
  output logic bus_drv_en_out,
  output logic aux_drv_en_out
);
  import hvsw_pkg::*;

  function automatic logic [1:0] sel_of(input logic [7:0] c);
    sel_of = c[CMD_SEL_LSB +: 2];
  endfunction : sel_of

  // ==================================================================
  // input synchronisation
  logic [SI_W-1:0] si;
  logic [SI_W-1:0] si_prev_q;
  logic [SI_W-1:0] si_rise;
  hvsw_sync #(.W(SI_W)) u_sync (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .d_in({adc_buf_en_in, core_low_in, supply_low_in, wake_oc_in,
           aux_short_in, bus_short_in, thermal_in, aux_pin_in,
           wake_pin_in}),
    .q_out(si)
  );
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      si_prev_q <= '0;
    end else begin
      si_prev_q <= si;
    end
  end
  assign si_rise = si & ~si_prev_q;

  // ==================================================================
  // timers
  hvsw_tmr_if xf_t ();
  hvsw_tmr_if mono_t ();
  hvsw_tmr_if wsc_t ();
  hvsw_timer #(.LIMIT(XFER_CYC)) u_xf_tmr ( // [R23]
    .mclk_in(mclk_in), .srst_in(srst_in), .t(xf_t.tmr));
  hvsw_timer #(.LIMIT(MONO_CYCLES)) u_mono_tmr ( // [R23]
    .mclk_in(mclk_in), .srst_in(srst_in), .t(mono_t.tmr));
  hvsw_timer #(.LIMIT(WSHORT_CYCLES)) u_wsc_tmr ( // [R23]
    .mclk_in(mclk_in), .srst_in(srst_in), .t(wsc_t.tmr));

  // ==================================================================
  // transfer sequencer
  hvsw_xfer_t st_q;
  logic busy_q;
  logic [7:0] cmd_q;
  logic auto_pend_q;
  logic sta_evt;
  logic start_host;
  logic start_auto;
  logic fin_host;
  logic fin_auto;
  logic host_wr;
  logic sta_rd;
  logic reen;

  assign start_host = !busy_q && cmd_wr_in;
  assign start_auto = !busy_q && !cmd_wr_in && (auto_pend_q || sta_evt);
  assign fin_host = busy_q && xf_t.done && (st_q == XF_HOST);
  assign fin_auto = busy_q && xf_t.done && (st_q == XF_AUTO);
  assign host_wr = fin_host && cmd_q[CMD_WR_BIT];
  assign sta_rd = fin_auto ||
                  (fin_host && !cmd_q[CMD_WR_BIT] &&
                   sel_of(cmd_q) == REG_CHG_STA);
  assign xf_t.run = busy_q; // [R24]

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      st_q <= XF_IDLE;
      busy_q <= 1'b0;
      cmd_q <= 8'h00;
    end else begin
      case (st_q)
        XF_IDLE: begin
          if (start_host) begin
            cmd_q <= cmd_wdata_in;
            st_q <= XF_HOST;
            busy_q <= 1'b1;
          end else if (start_auto) begin
            st_q <= XF_AUTO; // [R11]
            busy_q <= 1'b1; // [R24]
          end
        end
        XF_HOST, XF_AUTO: begin
          if (xf_t.done) begin
            st_q <= XF_IDLE;
            busy_q <= 1'b0; // [R24]
          end
        end
        default: begin
          st_q <= XF_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      auto_pend_q <= 1'b0;
    end else begin
      auto_pend_q <= (auto_pend_q || sta_evt) && !start_auto;
    end
  end

  // ==================================================================
  // configuration registers
  logic [7:0] cfg1_q;
  logic [7:0] cfg2_q;
  logic [7:0] dat_q;
  logic mono_done;
  assign mono_done = mono_t.done;
  assign reen = host_wr && sel_of(cmd_q) == REG_CFG_SECOND &&
                dat_q[CF2_REENABLE];

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      cfg1_q <= CFG_FIRST_RST;
      cfg2_q <= CFG_SECOND_RST;
    end else begin
      if (host_wr && sel_of(cmd_q) == REG_CFG_FIRST) begin
        cfg1_q <= dat_q; // [R18] [R19]
      end else if (mono_done) begin
        cfg1_q[CF1_WAKE_REQ] <= 1'b0; // [R20]
      end
      if (host_wr && sel_of(cmd_q) == REG_CFG_SECOND) begin
        cfg2_q <= dat_q & ~(8'h01 << CF2_REENABLE);
      end
    end
  end

  // ==================================================================
  // live monitor
  logic therm_q;
  logic bus_sc_q;
  logic aux_sc_q;
  logic wsc_q;
  logic lvf_q;
  logic lvf_en_prev_q;
  logic wsc_set;
  logic lvf_en;
  logic in_mode;
  logic [7:0] mon;
  assign lvf_en = cfg1_q[CF1_LVF_EN];
  assign in_mode = cfg2_q[CF2_WAKE_IN];
  assign wsc_set = wsc_t.done && !wsc_q; // [R21]

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      therm_q <= 1'b0;
      bus_sc_q <= 1'b0;
      aux_sc_q <= 1'b0;
      wsc_q <= 1'b0;
    end else begin
      therm_q <= si_rise[SI_THERM] || (therm_q && !reen); // [R3] [R22]
      bus_sc_q <= si_rise[SI_BUS_SC] || (bus_sc_q && !reen); // [R7]
      aux_sc_q <= si_rise[SI_AUX_SC] || (aux_sc_q && !reen); // [R8]
      wsc_q <= wsc_set || (wsc_q && !reen); // [R9] [R21]
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      lvf_q <= 1'b0;
      lvf_en_prev_q <= 1'b0;
    end else begin
      lvf_en_prev_q <= lvf_en;
      if (!lvf_en) begin
        lvf_q <= 1'b0;
      end else if (si[SI_CORE_LOW]) begin
        lvf_q <= 1'b0; // [R6]
      end else if (!lvf_en_prev_q) begin
        lvf_q <= 1'b1; // [R6]
      end
    end
  end

  always_comb begin
    mon = {in_mode && si[SI_WAKE], // [R1]
           therm_q, // [R3]
           in_mode && si[SI_AUX], // [R4]
           si[SI_BUF], // [R5]
           lvf_q, // [R6]
           bus_sc_q, aux_sc_q, wsc_q}; // [R7] [R8] [R9]
  end

  // ==================================================================
  // change-status register
  logic [4:0] sta_q;
  logic [4:0] sta_set;
  logic [7:0] sta_view;
  logic psm_bit;
  logic psm_rise;
  assign psm_bit = cfg1_q[CF1_PSM_EN] && si[SI_SUP_LOW]; // [R13]
  assign psm_rise = cfg1_q[CF1_PSM_EN] && si_rise[SI_SUP_LOW];
  assign sta_set = {in_mode && (si[SI_WAKE] != si_prev_q[SI_WAKE]), // [R14]
                    si_rise[SI_THERM], // [R2]
                    si_rise[SI_BUS_SC], // [R15]
                    si_rise[SI_AUX_SC], // [R16]
                    wsc_set}; // [R17]
  assign sta_view = {2'b00, psm_bit, sta_q}; // [R12] [R13]
  assign sta_evt = (|sta_set) || psm_rise;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      sta_q <= CHG_STA_RST[4:0]; // [R10]
    end else begin
      sta_q <= (sta_rd ? 5'h00 : sta_q) | sta_set; // [R10] [R15] [R16]
    end
  end

  // ==================================================================
  // data port
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      dat_q <= 8'h00;
    end else if (fin_auto) begin
      dat_q <= sta_view; // [R11]
    end else if (fin_host && !cmd_q[CMD_WR_BIT]) begin
      case (sel_of(cmd_q))
        REG_CFG_FIRST: dat_q <= cfg1_q;
        REG_CFG_SECOND: dat_q <= cfg2_q;
        REG_LIVE_MON: dat_q <= mon;
        default: dat_q <= sta_view;
      endcase
    end else if (dat_wr_in && !busy_q) begin
      dat_q <= dat_wdata_in;
    end
  end

  // ==================================================================
  // drivers and outputs
  logic wake_drv;
  logic wake_oe_q;
  logic bus_en_q;
  logic aux_en_q;
  logic irq_q;
  assign wake_drv = cfg1_q[CF1_WAKE_REQ] && !in_mode && !therm_q &&
                    !wsc_q; // [R22]
  assign mono_t.run = wake_oe_q && !cfg2_q[CF2_MONO_DIS]; // [R20]
  assign wsc_t.run = wake_oe_q && si[SI_WAKE_OC]; // [R21]

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      wake_oe_q <= 1'b0;
      bus_en_q <= 1'b0;
      aux_en_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      wake_oe_q <= wake_drv; // [R19]
      bus_en_q <= !bus_sc_q && !therm_q; // [R2] [R15]
      aux_en_q <= !aux_sc_q && !therm_q; // [R2]
      irq_q <= sta_evt; // [R14] [R21]
    end
  end

  assign cmd_busy_out = busy_q;
  assign dat_rdata_out = dat_q;
  assign hv_irq_out = irq_q;
  assign wake_pin_out = wake_oe_q;
  assign wake_pin_oe_out = wake_oe_q;
  assign bus_drv_en_out = bus_en_q;
  assign aux_drv_en_out = aux_en_q;

  // ==================================================================
  // assertions
  localparam int XF_N = int'(XFER_CYC);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  sequence s_xfer_start;
    $rose(busy_q);
  endsequence
  sequence s_xfer_end;
    $fell(busy_q);
  endsequence

  a_busy_len: assert property ( // [R24]
    s_xfer_start |-> ##[XF_N:XF_N] s_xfer_end)
    else $error("busy not exactly one transfer long");
  a_auto_load: assert property ( // [R11]
    fin_auto |=> dat_q == $past(sta_view))
    else $error("status not copied to data port");
  a_sta_reserved: assert property ( // [R12]
    fin_auto |=> dat_rdata_out[7:6] == 2'b00)
    else $error("reserved status bits not zero");
  a_therm_drv_off: assert property ( // [R2]
    therm_q |=> !bus_en_q && !aux_en_q && !wake_oe_q)
    else $error("driver on after thermal shutdown");
  a_wake_edge_irq: assert property ( // [R14]
    (in_mode && si[SI_WAKE] != si_prev_q[SI_WAKE]) |=>
      sta_q[ST_WAKE_EDGE] && hv_irq_out)
    else $error("wake edge missed");
  a_mono_timeout: assert property ( // [R20]
    (mono_done && !host_wr) |-> ##2 !wake_oe_q)
    else $error("wake driver kept past monoflop");
  a_bus_short: assert property ( // [R15]
    si_rise[SI_BUS_SC] |=> bus_sc_q && sta_q[ST_BUS_SC] ##1 !bus_en_q)
    else $error("bus short not handled");
  a_wsc_flag: assert property ( // [R21]
    wsc_set |=> wsc_q && sta_q[ST_WAKE_SC] && hv_irq_out)
    else $error("wake short not flagged");
  a_rd_clear: assert property ( // [R16]
    (sta_rd && !sta_set[ST_AUX_SC]) |=> !sta_q[ST_AUX_SC])
    else $error("aux status not cleared by read");
  a_lvf_low: assert property ( // [R6]
    (lvf_en && si[SI_CORE_LOW]) |=> !mon[MON_LVF])
    else $error("low-voltage flag not cleared");
endmodule : hvsw_top
`default_nettype wire

// ==== test/hvsw_bus_model.sv ====
// behavioural model of the wake bus and the aux pin outside the block
`default_nettype none
module hvsw_bus_model (
  // wake driver side
  input wire logic drv_in,
  input wire logic drv_oe_in,
  // test controls
  input wire logic ext_high_in,
  input wire logic gnd_short_in,
  input wire logic aux_level_in,
  // pin levels
  output logic wake_pin_out,
  output logic wake_oc_out,
  output logic aux_pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==================================================================
  // pins
  // pull-down holds the bus low unless someone drives it high
  assign wake_pin_out = gnd_short_in ? 1'h0 :
    ((drv_oe_in & drv_in) | ext_high_in);
  // sourcing into a grounded bus draws overcurrent
  assign wake_oc_out = gnd_short_in & drv_oe_in & drv_in;
  assign aux_pin_out = aux_level_in;
endmodule : hvsw_bus_model
`default_nettype wire

// ==== test/hvsw_top_tb_top.sv ====
// self-checking bench for the hv status and wake-pin block
`default_nettype none
module hvsw_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import hvsw_pkg::*;
  // ==================================================================
  // signals
  logic mclk_in = 1'h0;
  logic srst_in = 1'h1;
  logic cmd_wr = 1'h0, dat_wr = 1'h0, early = 1'h0;
  logic [7:0] cmd_wdata = 8'h00, dat_wdata = 8'h00, rdata, dat;
  logic thermal = 1'h0, bus_sc = 1'h0, aux_sc = 1'h0, sup_low = 1'h0;
  logic core_low = 1'h0, buf_en = 1'h1, ext_high = 1'h0;
  logic gnd_short = 1'h0, aux_lvl = 1'h1;
  logic busy, irq, wake_out, wake_oe, wake_pin, wake_oc, aux_pin;
  logic bus_en, aux_en;
  int n_fail = 0;
  int comparisons = 0;
  always #12.5 mclk_in = ~mclk_in;
  // ==================================================================
  // design and far side
  hvsw_top #(.MONO_CYCLES(50), .WSHORT_CYCLES(20)) uut (
    .mclk_in(mclk_in), .srst_in(srst_in), .cmd_wr_in(cmd_wr),
    .cmd_wdata_in(cmd_wdata), .dat_wr_in(dat_wr),
    .dat_wdata_in(dat_wdata), .cmd_busy_out(busy), .dat_rdata_out(dat),
    .hv_irq_out(irq), .thermal_in(thermal), .bus_short_in(bus_sc),
    .aux_short_in(aux_sc), .wake_oc_in(wake_oc), .supply_low_in(sup_low),
    .core_low_in(core_low), .adc_buf_en_in(buf_en),
    .wake_pin_in(wake_pin), .wake_pin_out(wake_out),
    .wake_pin_oe_out(wake_oe), .aux_pin_in(aux_pin),
    .bus_drv_en_out(bus_en), .aux_drv_en_out(aux_en));
  hvsw_bus_model far_side (
    .drv_in(wake_out), .drv_oe_in(wake_oe), .ext_high_in(ext_high),
    .gnd_short_in(gnd_short), .aux_level_in(aux_lvl),
    .wake_pin_out(wake_pin), .wake_oc_out(wake_oc),
    .aux_pin_out(aux_pin));
  // ==================================================================
  // shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick();
    @(posedge mclk_in);
    #1;
  endtask : tick
  task automatic wait_idle();
    int g;
    g = 0;
    repeat (8) tick();
    while (busy !== 1'h0 && g < 2000) begin
      tick();
      g++;
    end
    check(16'(busy), 16'h0000);
  endtask : wait_idle
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] data);
    int n;
    n = 0;
    early = 1'h0;
    wait_idle();
    @(posedge mclk_in);
    dat_wr <= 1'h1;
    dat_wdata <= data;
    @(posedge mclk_in);
    dat_wr <= 1'h0;
    cmd_wr <= 1'h1;
    cmd_wdata <= cmd;
    @(posedge mclk_in);
    cmd_wr <= 1'h0;
    #1;
    // busy is already up one step after the edge that takes the command
    while (busy === 1'h1 && n < 2000) begin
      n++;
      if (wake_oe === 1'h1) early = 1'h1;
      tick();
    end
    rdata = dat;
    check(16'(n), 16'(XFER_CYC));
  endtask : xfer
  task automatic rd(input logic [1:0] idx, input logic [7:0] exp);
    xfer({6'h00, idx}, 8'h00);
    check(16'(rdata), 16'(exp));
  endtask : rd
  task automatic wr(input logic [1:0] idx, input logic [7:0] val);
    xfer({4'h0, 1'h1, 1'h0, idx}, val);
  endtask : wr
  task automatic wait_irq(input logic [7:0] exp);
    int g;
    g = 0;
    while (irq !== 1'h1 && g < 60) begin
      tick();
      g++;
    end
    check(16'(irq), 16'h0001);
    wait_idle();
    check(16'(dat), 16'(exp));
  endtask : wait_irq
  // ==================================================================
  // scenarios
  task automatic t_reset();
    rd(REG_CHG_STA, 8'h00);
    rd(REG_LIVE_MON, 8'h10);
    @(posedge mclk_in);
    buf_en <= 1'h0;
    rd(REG_LIVE_MON, 8'h00);
    @(posedge mclk_in);
    buf_en <= 1'h1;
    check(16'({bus_en, aux_en}), 16'h0003);
    $display("test reset done");
  endtask : t_reset
  task automatic t_wake_out();
    wr(REG_CFG_FIRST, 8'h10);
    check(16'(early), 16'h0000);
    tick();
    check(16'({wake_oe, wake_out, wake_pin}), 16'h0007);
    repeat (30) tick();
    check(16'(wake_oe), 16'h0001);
    repeat (30) tick();
    check(16'({wake_oe, wake_pin}), 16'h0000);
    rd(REG_CFG_FIRST, 8'h00);
    // monoflop disabled: driver must stay on past the timeout
    wr(REG_CFG_SECOND, 8'h02);
    wr(REG_CFG_FIRST, 8'h10);
    check(16'(early), 16'h0000);
    repeat (60) tick();
    check(16'(wake_oe), 16'h0001);
    wr(REG_CFG_FIRST, 8'h00);
    tick();
    check(16'({wake_oe, wake_pin}), 16'h0000);
    wr(REG_CFG_SECOND, 8'h00);
    $display("test wake output done");
  endtask : t_wake_out
  task automatic t_wake_in();
    wr(REG_CFG_SECOND, 8'h10);
    @(posedge mclk_in);
    ext_high <= 1'h1;
    wait_irq(8'h10);
    rd(REG_LIVE_MON, 8'hB0);
    wr(REG_CFG_SECOND, 8'h00);
    @(posedge mclk_in);
    ext_high <= 1'h0;
    rd(REG_LIVE_MON, 8'h10);
    $display("test wake input done");
  endtask : t_wake_in
  task automatic t_shorts();
    @(posedge mclk_in);
    bus_sc <= 1'h1;
    aux_sc <= 1'h1;
    wait_irq(8'h06);
    check(16'({bus_en, aux_en}), 16'h0000);
    rd(REG_LIVE_MON, 8'h16);
    rd(REG_CHG_STA, 8'h00);
    @(posedge mclk_in);
    bus_sc <= 1'h0;
    aux_sc <= 1'h0;
    wr(REG_CFG_SECOND, 8'h08);
    rd(REG_LIVE_MON, 8'h10);
    check(16'({bus_en, aux_en}), 16'h0003);
    $display("test shorts done");
  endtask : t_shorts
  task automatic t_thermal();
    @(posedge mclk_in);
    thermal <= 1'h1;
    wait_irq(8'h08);
    check(16'({bus_en, aux_en, wake_oe}), 16'h0000);
    rd(REG_LIVE_MON, 8'h50);
    wr(REG_CFG_FIRST, 8'h10);
    tick();
    check(16'(wake_oe), 16'h0000);
    @(posedge mclk_in);
    thermal <= 1'h0;
    wr(REG_CFG_SECOND, 8'h08);
    tick();
    check(16'(wake_oe), 16'h0001);
    @(posedge mclk_in);
    gnd_short <= 1'h1;
    wait_irq(8'h01);
    rd(REG_LIVE_MON, 8'h11);
    @(posedge mclk_in);
    gnd_short <= 1'h0;
    wr(REG_CFG_SECOND, 8'h08);
    wr(REG_CFG_FIRST, 8'h00);
    rd(REG_LIVE_MON, 8'h10);
    $display("test thermal and wake short done");
  endtask : t_thermal
  task automatic t_supply();
    wr(REG_CFG_FIRST, 8'h0C);
    rd(REG_LIVE_MON, 8'h18);
    @(posedge mclk_in);
    core_low <= 1'h1;
    rd(REG_LIVE_MON, 8'h10);
    @(posedge mclk_in);
    core_low <= 1'h0;
    sup_low <= 1'h1;
    rd(REG_CHG_STA, 8'h20);
    @(posedge mclk_in);
    sup_low <= 1'h0;
    rd(REG_CHG_STA, 8'h00);
    rd(REG_LIVE_MON, 8'h10);
    $display("test supply monitors done");
  endtask : t_supply
  // ==================================================================
  // run control
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #1_000_000;
    n_fail++;
    $display("watchdog expired at %0t", $time);
    wrap_up();
  end
  initial begin
    repeat (2) @(posedge mclk_in);
    srst_in <= 1'h0;
    t_reset();
    t_wake_out();
    t_wake_in();
    t_shorts();
    t_thermal();
    t_supply();
    wrap_up();
  end
endmodule : hvsw_top_tb_top
`default_nettype wire
